/* File: rtl/rls_defines.vh */
/*
 * Constants for the remote link supervisor: register offsets, field
 * positions, reset values and timing figures.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef RLS_DEFINES_VH
`define RLS_DEFINES_VH

// Register byte offsets on the AHB-Lite bus.
`define RLS_OFF_CTRL 8'h00
`define RLS_OFF_TIMEOUT 8'h04
`define RLS_OFF_PORT 8'h08
`define RLS_OFF_IPADDR 8'h0C
`define RLS_OFF_MASK 8'h10
`define RLS_OFF_GW 8'h14
`define RLS_OFF_STATUS 8'h18
`define RLS_OFF_CUR 8'h1C
`define RLS_OFF_MAX 8'h20
`define RLS_OFF_MIN 8'h24
`define RLS_OFF_OUTS 8'h28
`define RLS_OFF_MON 8'h2C

// Control register fields.
`define RLS_CTRL_AUTO 0
`define RLS_CTRL_DEFAULTS 1

// Status register fields.
`define RLS_ST_CONN 0
`define RLS_ST_REFUSED 1
`define RLS_ST_MON_REJ 2

// Reset values and limits.
`define RLS_PORT_DEFAULT 16'h083E
`define RLS_TO_STEPS_DEFAULT 8'h14
`define RLS_TO_STEPS_MIN 8'h01
`define RLS_ADDR_DEFAULT 32'h00000000
`define RLS_CYCLE_NONE 32'h00000000
`define RLS_MIN_START 32'hFFFFFFFF

// Timing: one timeout step, blink half period, clock rate.
`define RLS_STEP_MS 100
`define RLS_BLINK_MS 250
`define RLS_CLK_KHZ 250000

`endif

/* File: rtl/rls_ms_tick.v */
/*
 * Divider that turns the system clock into a one-cycle pulse every
 * millisecond.
 * Assumes a single clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rls_defines.vh"

module rls_ms_tick #(
    parameter integer CYCLES_PER_MS = `RLS_CLK_KHZ
) (
    // Clock and reset.
    input wire clock,
    input wire reset,
    // Millisecond enable pulse.
    output reg tick
);
    reg [31:0] count_reg;

    // Count up the cycles of one millisecond and pulse at the wrap.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            count_reg <= 32'h00000000;
            tick <= 1'b0;
        end else if (count_reg == CYCLES_PER_MS - 1) begin
            count_reg <= 32'h00000000;
            tick <= 1'b1;
        end else begin
            count_reg <= count_reg + 32'h00000001;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/rls_ahb_regs.v */
/*
 * AHB-Lite slave front end: captures the address phase and produces
 * one-cycle read and write strobes in the data phase.
 * Assumes single word transfers; always answers OKAY with no wait.
 */
`timescale 1ns/1ps
`default_nettype none

module rls_ahb_regs (
    // Clock and reset.
    input wire clock,
    input wire reset,
    // AHB-Lite address phase.
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    // Strobes toward the register file.
    output reg wr_stb,
    output reg rd_stb,
    output reg [7:0] addr
);
    // Latch a valid transfer at the end of its address phase.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            addr <= 8'h00;
        end else begin
            wr_stb <= hsel & hready & htrans[1] & hwrite;
            rd_stb <= hsel & hready & htrans[1] & ~hwrite;
            if (hsel & hready & htrans[1]) begin
                addr <= haddr;
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/rls_supervisor.v */
/*
 * Remote I/O slave link supervisor: connection state, master-silence
 * watchdog, output gating, status LED and communication cycle figures,
 * with settings reached over AHB-Lite.
 * Assumes the network stack presents one pulse per valid master message
 * and per connection attempt, all on this clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rls_defines.vh"

module rls_supervisor #(
    parameter integer NUM_OUT = 16,
    parameter integer NUM_IN = 16,
    parameter integer CYCLES_PER_MS = `RLS_CLK_KHZ
) (
    // Clock and reset.
    input wire clock,
    input wire reset,
    // AHB-Lite slave.
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // Link events from the network stack.
    input wire conn_req,
    input wire msg_valid,
    input wire [NUM_OUT-1:0] msg_outputs,
    output wire conn_accept,
    output wire conn_refuse,
    // Local input image and its delivery to the master.
    input wire [NUM_IN-1:0] local_inputs,
    output reg [NUM_IN-1:0] master_inputs,
    output reg master_inputs_valid,
    // Physical outputs and indicator.
    output reg [NUM_OUT-1:0] slave_outputs,
    output reg status_led,
    // Local device monitor (read-only).
    input wire mon_wr,
    output wire mon_wr_refused
);
    // One-hot link states.
    localparam [1:0] ST_DISC = 2'b01;
    localparam [1:0] ST_CONN = 2'b10;
    localparam [31:0] STEP_MS = `RLS_STEP_MS;
    localparam [31:0] BLINK_MS = `RLS_BLINK_MS;

    wire wr_stb;
    wire rd_stb;
    wire [7:0] addr;
    wire ms_tick;
    reg [1:0] state_reg;
    reg [7:0] timeout_reg;
    reg [15:0] port_reg;
    reg auto_reg;
    reg [31:0] ip_reg;
    reg [31:0] mask_reg;
    reg [31:0] gw_reg;
    reg [31:0] silence_reg;
    reg [31:0] cycle_cnt_reg;
    reg [31:0] cur_reg;
    reg [31:0] max_reg;
    reg [31:0] min_reg;
    reg [NUM_OUT-1:0] out_img_reg;
    reg [31:0] blink_reg;
    reg refused_reg;
    reg mon_rej_reg;
    wire connected;
    wire timed_out;

    // Clamp a written timeout to at least one step.
    function [7:0] clamp_steps;
        input [31:0] value;
        begin
            if (value[7:0] < `RLS_TO_STEPS_MIN) begin
                clamp_steps = `RLS_TO_STEPS_MIN;
            end else begin
                clamp_steps = value[7:0];
            end
        end
    endfunction

    rls_ahb_regs u_bus (
        .clock(clock),
        .reset(reset),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .addr(addr)
    );

    rls_ms_tick #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_tick (
        .clock(clock),
        .reset(reset),
        .tick(ms_tick)
    );

    // The slave answers every transfer at once with OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    assign connected = state_reg[1];
    // Silence equal to or longer than the programmed span counts as timeout.
    assign timed_out = silence_reg >= timeout_reg * STEP_MS;
    // A single master: accept only while disconnected, refuse otherwise.
    assign conn_accept = conn_req & ~connected;
    assign conn_refuse = conn_req & connected;
    // Monitor writes are never applied.
    assign mon_wr_refused = mon_wr;

    // Software-writable settings.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            timeout_reg <= `RLS_TO_STEPS_DEFAULT;
            port_reg <= `RLS_PORT_DEFAULT;
            auto_reg <= 1'b0;
            ip_reg <= `RLS_ADDR_DEFAULT;
            mask_reg <= `RLS_ADDR_DEFAULT;
            gw_reg <= `RLS_ADDR_DEFAULT;
        end else if (wr_stb) begin
            if (addr == `RLS_OFF_CTRL) begin
                if (hwdata[`RLS_CTRL_DEFAULTS]) begin
                    port_reg <= `RLS_PORT_DEFAULT;
                    timeout_reg <= `RLS_TO_STEPS_DEFAULT;
                    auto_reg <= 1'b0;
                end else begin
                    auto_reg <= hwdata[`RLS_CTRL_AUTO];
                end
            end else if (addr == `RLS_OFF_TIMEOUT) begin
                timeout_reg <= clamp_steps(hwdata);
            end else if (addr == `RLS_OFF_PORT) begin
                port_reg <= hwdata[15:0];
            end else if (addr == `RLS_OFF_IPADDR) begin
                ip_reg <= hwdata;
            end else if (addr == `RLS_OFF_MASK) begin
                mask_reg <= hwdata;
            end else if (addr == `RLS_OFF_GW) begin
                gw_reg <= hwdata;
            end
        end
    end

    // Link state machine with the silence watchdog.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg <= ST_DISC;
            silence_reg <= 32'h00000000;
        end else begin
            case (state_reg)
                ST_DISC: begin
                    silence_reg <= 32'h00000000;
                    if (conn_accept) begin
                        state_reg <= ST_CONN;
                    end
                end
                ST_CONN: begin
                    if (msg_valid) begin
                        silence_reg <= 32'h00000000;
                    end else if (timed_out) begin
                        state_reg <= ST_DISC;
                    end else if (ms_tick) begin
                        silence_reg <= silence_reg + 32'h00000001;
                    end
                end
                default: begin
                    state_reg <= ST_DISC;
                end
            endcase
        end
    end

    // Cycle measurement: ms between messages, with current, largest and smallest.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            cycle_cnt_reg <= 32'h00000000;
            cur_reg <= `RLS_CYCLE_NONE;
            max_reg <= `RLS_CYCLE_NONE;
            min_reg <= `RLS_MIN_START;
        end else if (!connected) begin
            cycle_cnt_reg <= 32'h00000000;
            cur_reg <= `RLS_CYCLE_NONE;
            max_reg <= `RLS_CYCLE_NONE;
            min_reg <= `RLS_MIN_START;
        end else if (msg_valid) begin
            cycle_cnt_reg <= 32'h00000000;
            cur_reg <= cycle_cnt_reg;
            if (cycle_cnt_reg > max_reg) begin
                max_reg <= cycle_cnt_reg;
            end
            if (cycle_cnt_reg < min_reg) begin
                min_reg <= cycle_cnt_reg;
            end
        end else if (ms_tick) begin
            cycle_cnt_reg <= cycle_cnt_reg + 32'h00000001;
        end
    end

    // Output image and input delivery, refreshed every cycle.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            out_img_reg <= {NUM_OUT{1'b0}};
            slave_outputs <= {NUM_OUT{1'b0}};
            master_inputs <= {NUM_IN{1'b0}};
            master_inputs_valid <= 1'b0;
        end else begin
            if (!connected) begin
                out_img_reg <= {NUM_OUT{1'b0}};
            end else if (msg_valid) begin
                out_img_reg <= msg_outputs;
            end
            // Gate with the live state so a timeout turns outputs off at once.
            if (connected && !timed_out) begin
                slave_outputs <= msg_valid ? msg_outputs : out_img_reg;
                master_inputs <= local_inputs;
                master_inputs_valid <= 1'b1;
            end else begin
                slave_outputs <= {NUM_OUT{1'b0}};
                master_inputs <= {NUM_IN{1'b0}};
                master_inputs_valid <= 1'b0;
            end
        end
    end

    // Status LED: steady when connected, blinking when disconnected.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            blink_reg <= 32'h00000000;
            status_led <= 1'b0;
        end else if (connected) begin
            blink_reg <= 32'h00000000;
            status_led <= 1'b1;
        end else if (ms_tick) begin
            if (blink_reg == BLINK_MS - 1) begin
                blink_reg <= 32'h00000000;
                status_led <= ~status_led;
            end else begin
                blink_reg <= blink_reg + 32'h00000001;
            end
        end
    end

    // Sticky event flags; the event wins over a clear in the same cycle.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            refused_reg <= 1'b0;
            mon_rej_reg <= 1'b0;
        end else begin
            if (conn_refuse) begin
                refused_reg <= 1'b1;
            end else if (wr_stb && addr == `RLS_OFF_STATUS && hwdata[`RLS_ST_REFUSED]) begin
                refused_reg <= 1'b0;
            end
            if (mon_wr) begin
                mon_rej_reg <= 1'b1;
            end else if (wr_stb && addr == `RLS_OFF_STATUS && hwdata[`RLS_ST_MON_REJ]) begin
                mon_rej_reg <= 1'b0;
            end
        end
    end

    // Read data for the data phase; unmapped addresses read zero.
    always @* begin
        hrdata = 32'h00000000;
        if (rd_stb) begin
            if (addr == `RLS_OFF_CTRL) begin
                hrdata = {31'h00000000, auto_reg};
            end else if (addr == `RLS_OFF_TIMEOUT) begin
                hrdata = {24'h000000, timeout_reg};
            end else if (addr == `RLS_OFF_PORT) begin
                hrdata = {16'h0000, port_reg};
            end else if (addr == `RLS_OFF_IPADDR) begin
                hrdata = ip_reg;
            end else if (addr == `RLS_OFF_MASK) begin
                hrdata = mask_reg;
            end else if (addr == `RLS_OFF_GW) begin
                hrdata = gw_reg;
            end else if (addr == `RLS_OFF_STATUS) begin
                hrdata = {29'h00000000, mon_rej_reg, refused_reg, connected};
            end else if (addr == `RLS_OFF_CUR) begin
                hrdata = cur_reg;
            end else if (addr == `RLS_OFF_MAX) begin
                hrdata = max_reg;
            end else if (addr == `RLS_OFF_MIN) begin
                hrdata = connected ? min_reg : `RLS_CYCLE_NONE;
            end else if (addr == `RLS_OFF_OUTS) begin
                hrdata = {{(32-NUM_OUT){1'b0}}, slave_outputs};
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/rls_chk.sv */
/* Port checker for the link supervisor.
   Assumes one clock and an active-high asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module rls_chk #(
    parameter integer NUM_OUT = 16,
    parameter integer NUM_IN = 16
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Link events.
    input wire logic conn_req,
    input wire logic conn_accept,
    input wire logic conn_refuse,
    input wire logic msg_valid,
    input wire logic [NUM_OUT-1:0] msg_outputs,
    // Images and indicator.
    input wire logic [NUM_IN-1:0] local_inputs,
    input wire logic [NUM_IN-1:0] master_inputs,
    input wire logic master_inputs_valid,
    input wire logic [NUM_OUT-1:0] slave_outputs,
    input wire logic status_led,
    // Monitor.
    input wire logic mon_wr,
    input wire logic mon_wr_refused
);
    // All checks share one clock and reset.
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // An accepted attempt is followed by a lit indicator.
    sequence s_accept; conn_accept; endsequence
    sequence s_lit; ##[1:2] status_led; endsequence
    a_accept_lights: assert property (s_accept |-> s_lit)
        else $error("indicator not lit after accept");
    a_answer_each: assert property (conn_req |-> (conn_accept ^ conn_refuse))
        else $error("attempt not answered once");
    a_refuse_when_lit: assert property (conn_refuse |-> status_led)
        else $error("refuse while not connected");
    a_busy_refuses: assert property (conn_req && master_inputs_valid |-> conn_refuse)
        else $error("second master not refused");
    a_accept_idle: assert property (conn_accept |-> !master_inputs_valid && slave_outputs == '0)
        else $error("accept while outputs live");
    a_mon_refused: assert property (mon_wr |-> mon_wr_refused)
        else $error("monitor write not refused");
    a_dark_off: assert property (!status_led |-> slave_outputs == '0 && !master_inputs_valid)
        else $error("outputs live while dark");
    a_invalid_zero: assert property (!master_inputs_valid |-> master_inputs == '0)
        else $error("inputs delivered while invalid");
    a_inputs_follow: assert property (master_inputs_valid && $past(master_inputs_valid)
        |-> master_inputs == $past(local_inputs))
        else $error("inputs not passed on");
    a_msg_loads: assert property (msg_valid && master_inputs_valid
        |=> slave_outputs == $past(msg_outputs))
        else $error("outputs do not follow message");
    c_accept: cover property (s_accept);
endmodule
bind rls_supervisor rls_chk #(.NUM_OUT(NUM_OUT), .NUM_IN(NUM_IN)) u_chk (.clock(clock), .reset(reset),
    .conn_req(conn_req), .conn_accept(conn_accept), .conn_refuse(conn_refuse), .msg_valid(msg_valid),
    .msg_outputs(msg_outputs), .local_inputs(local_inputs), .master_inputs(master_inputs),
    .master_inputs_valid(master_inputs_valid), .slave_outputs(slave_outputs), .status_led(status_led),
    .mon_wr(mon_wr), .mon_wr_refused(mon_wr_refused));
`default_nettype wire

/* File: tb/rls_master_model.sv */
/* Model of the remote master that connects and sends output messages.
   Assumes the testbench calls its tasks and shares the clock. */
`timescale 1ns/1ps
`default_nettype none
module rls_master_model #(
    parameter integer N = 16
) (
    // Clock.
    input wire logic clock,
    // Link events toward the slave.
    output logic conn_req,
    output logic msg_valid,
    output logic [N-1:0] msg_outputs
);
    // Idle until a task asks for traffic.
    initial begin
        conn_req = 1'b0;
        msg_valid = 1'b0;
        msg_outputs = '0;
    end
    // One connection attempt, a single-cycle pulse.
    task automatic connect();
        @(posedge clock);
        conn_req <= 1'b1;
        @(posedge clock);
        conn_req <= 1'b0;
    endtask
    // Waits a chosen delay, sends one message, then scrambles the stale value.
    task automatic send(input logic [N-1:0] v, input int g);
        repeat (g) @(posedge clock);
        msg_valid <= 1'b1;
        msg_outputs <= v;
        @(posedge clock);
        msg_valid <= 1'b0;
        msg_outputs <= ~v;
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
/* Self-checking bench for the link supervisor.
   Assumes the design constants header is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "rls_defines.vh"
module tb_top;
    localparam integer CPM = 10;
    logic clock, reset, hsel, hwrite, mon_wr;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [31:0] hwdata, r, v32;
    logic [15:0] local_inputs, v;
    wire hreadyout, hresp, conn_req, msg_valid, conn_accept, conn_refuse, master_inputs_valid, status_led;
    wire mon_wr_refused;
    wire [31:0] hrdata;
    wire [15:0] msg_outputs, master_inputs, slave_outputs;
    int fail_count, compares, i, n, g, mx;
    logic b;
    // Design, master model and clock.
    rls_supervisor #(.CYCLES_PER_MS(CPM)) dut (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .conn_req(conn_req), .msg_valid(msg_valid),
        .msg_outputs(msg_outputs), .conn_accept(conn_accept), .conn_refuse(conn_refuse),
        .local_inputs(local_inputs), .master_inputs(master_inputs), .master_inputs_valid(master_inputs_valid),
        .slave_outputs(slave_outputs), .status_led(status_led), .mon_wr(mon_wr), .mon_wr_refused(mon_wr_refused));
    rls_master_model mm (.clock(clock), .conn_req(conn_req), .msg_valid(msg_valid), .msg_outputs(msg_outputs));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Exact and one-millisecond-tolerant comparisons.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task near(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if ((^got === 1'bx) || got > exp + 1 || got + 1 < exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One single-word transfer; read data lands in r.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(r, e);
        chk(32'(hresp), 32'h0);
    endtask
    function logic [31:0] to_steps(input logic [31:0] d);
        return (d[7:0] == 8'h00) ? 32'h1 : {24'h0, d[7:0]};
    endfunction
    // One message g ms after the previous event, then its effects.
    task msg(input int ms);
        @(posedge clock);
        local_inputs <= 16'($urandom);
        v = 16'($urandom);
        mm.send(v, ms * CPM - 2);
        @(negedge clock);
        chk(32'(slave_outputs), 32'(v));
        chk(32'(master_inputs), 32'(local_inputs));
        chk(32'(status_led), 32'h1);
    endtask
    task summarize();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard.
    initial begin
        repeat (40000) @(posedge clock);
        fail_count++;
        summarize();
    end
    // Main sequence.
    initial begin
        void'($urandom(32'h36FC));
        {reset, hsel, hwrite, mon_wr, haddr, htrans, hwdata, local_inputs} = '0;
        reset = 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        rd(`RLS_OFF_TIMEOUT, 32'h14);
        rd(`RLS_OFF_PORT, 32'h083E);
        rd(`RLS_OFF_CUR, 32'h0);
        rd(`RLS_OFF_MIN, 32'h0);
        rd(8'h30, 32'h0);
        for (i = 0; i < 3; i++) begin
            v32 = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFF : ($urandom & 32'hFFFF);
            bus(1'b1, `RLS_OFF_PORT, v32);
            rd(`RLS_OFF_PORT, v32);
            v32 = (i == 0) ? 32'h0 : (i == 1) ? 32'hFF : $urandom;
            bus(1'b1, `RLS_OFF_TIMEOUT, v32);
            rd(`RLS_OFF_TIMEOUT, to_steps(v32));
            v32 = $urandom;
            bus(1'b1, `RLS_OFF_IPADDR + 8'(4 * i), v32);
            rd(`RLS_OFF_IPADDR + 8'(4 * i), v32);
        end
        bus(1'b1, `RLS_OFF_CTRL, 32'h1);
        rd(`RLS_OFF_CTRL, 32'h1);
        bus(1'b1, `RLS_OFF_CTRL, 32'h2);
        rd(`RLS_OFF_PORT, 32'h083E);
        rd(`RLS_OFF_TIMEOUT, 32'h14);
        rd(`RLS_OFF_CTRL, 32'h0);
        bus(1'b1, `RLS_OFF_TIMEOUT, 32'h1);
        @(posedge clock) mon_wr <= 1'b1;
        @(posedge clock) mon_wr <= 1'b0;
        rd(`RLS_OFF_STATUS, 32'h4);
        bus(1'b1, `RLS_OFF_STATUS, 32'h4);
        mm.send(16'hA5A5, 0);
        @(negedge clock);
        chk(32'(slave_outputs), 32'h0);
        chk(32'(master_inputs_valid), 32'h0);
        // Indicator half period while disconnected.
        for (i = 0; i < 2; i++) begin
            b = status_led;
            n = 0;
            while (status_led === b) begin
                @(posedge clock);
                n++;
            end
        end
        chk(n, 250 * CPM);
        mm.connect();
        mx = 5;
        for (i = 0; i < 4; i++) begin
            g = (i == 0) ? 5 : 10 + $urandom % 21;
            mx = (g > mx) ? g : mx;
            msg(g);
        end
        rd(`RLS_OFF_STATUS, 32'h1);
        rd(`RLS_OFF_OUTS, 32'(v));
        bus(1'b0, `RLS_OFF_CUR, 32'h0);
        near(r, g);
        bus(1'b0, `RLS_OFF_MAX, 32'h0);
        near(r, mx);
        bus(1'b0, `RLS_OFF_MIN, 32'h0);
        near(r, 5);
        mm.connect();
        rd(`RLS_OFF_STATUS, 32'h3);
        bus(1'b1, `RLS_OFF_STATUS, 32'h2);
        msg(1);
        repeat (950) @(negedge clock);
        chk(32'(slave_outputs), 32'(v));
        repeat (80) @(negedge clock);
        chk(32'(slave_outputs), 32'h0);
        rd(`RLS_OFF_STATUS, 32'h0);
        rd(`RLS_OFF_OUTS, 32'h0);
        rd(`RLS_OFF_MAX, 32'h0);
        mm.connect();
        msg(8);
        msg(9);
        bus(1'b0, `RLS_OFF_MAX, 32'h0);
        near(r, 9);
        bus(1'b0, `RLS_OFF_MIN, 32'h0);
        near(r, 8);
        summarize();
    end
endmodule
`default_nettype wire
